// ---- rtl/adc_result_coding_ref_monitor.sv ----
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// RULE1 - Unipolar results use straight binary
// RULE2 - Bipolar results use offset binary
// RULE3 - Polarity bit selects result coding
// RULE4 - Clock select field picks clock source
// RULE5 - Internal clock may drive clock pin
// RULE6 - Burnout currents switch together, follow channel
// RULE7 - Reference select claims second pair pins
// RULE8 - Detection runs only when enabled
// RULE9 - Invalid reference sets no-reference flag
// RULE10 - No reference forces all-ones results
// RULE11 - No reference blocks coefficient, sets error
// RULE12 - Host checks flag on all-ones result
// RULE13 - Host reads error after calibration
// RULE14 - Clamp applied before data register
module adc_result_coding_ref_monitor
   import adc_ctrl_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   input  wire adc_ctrl_pkg::avs_req_t         avs_req,
   output      logic [adc_ctrl_pkg::DATA_W-1:0] avs_readdata,
   output      logic                           avs_waitrequest,
   input  wire adc_ctrl_pkg::sample_t          conv_sample,
   input  wire adc_ctrl_pkg::sample_t          cal_sample,
   input  wire logic                           ref_invalid_pin,
   input  wire logic                           internal_osc,
   output      logic [1:0]                     clock_source,
   output      logic                           master_clock_pin_b_out,
   output      logic                           master_clock_pin_b_oe,
   output      logic                           burnout_source_en,
   output      logic                           burnout_sink_en,
   output      logic [1:0]                     burnout_channel,
   output      logic                           reference_select,
   output      logic [1:0]                     second_reference_pair_out,
   output      logic [1:0]                     second_reference_pair_oe,
   output      logic [1:0]                     op_mode
);

   import adc_ctrl_pkg::*;

   // ****************************************************
   // Declarations
   // ****************************************************
   logic [5:0]        config_reg,    config_next;            // Configuration bits
   logic [1:0]        clk_sel_reg,   clk_sel_next;           // Clock select field
   op_mode_t          op_reg,        op_next;                // Operating mode
   logic [RES_W-1:0]  data_reg,      data_next;              // Stored result
   logic [RES_W-1:0]  offset_reg,    offset_next;            // Offset coefficient
   logic [RES_W-1:0]  fullscale_reg, fullscale_next;         // Full-scale coefficient
   logic [2:0]        gpo_reg,       gpo_next;               // Second pair outputs
   logic              ready_reg,     ready_next;             // Result waiting
   logic              error_reg,     error_next;             // Calibration error
   logic              no_reference_flag_reg,     no_reference_flag_next;             // No-reference flag
   logic              no_reference_flag_seen_reg, no_reference_flag_seen_next;       // Flag seen during cal
   logic              wait_reg,      wait_next;              // Waitrequest flop
   logic [DATA_W-1:0] rdata_reg,     rdata_next;             // Read data flop
   logic [1:0]        pin_out_next;                          // Second pair drive
   logic [1:0]        pin_oe_next;                           // Second pair enable
   logic              clk_pin_reg,   clk_pin_next;           // Clock pin level
   logic              clk_oe_reg,    clk_oe_next;            // Clock pin enable
   logic              burn_reg,      burn_next;              // Burnout switch
   logic [1:0]        chan_reg,      chan_next;              // Burnout routing
   logic              reference_select_reg,    reference_select_next;            // Reference pair
   logic [1:0]        pin_out_reg;                           // Second pair drive flop
   logic [1:0]        pin_oe_reg;                            // Second pair enable flop
   logic              ref_bad;                               // Synchronised comparator
   logic              osc_sync;                              // Synchronised oscillator
   logic [RES_W-1:0]  coded;                                 // Coded, clamped result
   logic              take_wr;                               // Write accepted this edge
   logic              take_rd;                               // Read accepted this edge
   logic              in_cal;                                // Calibration running
   logic [DATA_W-1:0] status_word;                           // Assembled status

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   pin_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in ({internal_osc, ref_invalid_pin}),
      .sync_out ({osc_sync, ref_bad})
   );

   // ****************************************************
   // Result coding
   // ****************************************************
   result_coder u_coder (
      .unipolar (config_reg[CFG_UNIPOLAR]),                  // [RULE3]
      .clamp    (no_reference_flag_reg),                                 // [RULE10]
      .value    (conv_sample.value),
      .code     (coded)
   );

   // Bus acceptance and helpers
   assign take_wr     = avs_req.write & ~wait_reg;
   assign take_rd     = avs_req.read & ~wait_reg;
   assign in_cal      = (op_reg == OP_CAL_ZERO) || (op_reg == OP_CAL_FULL);
   assign status_word = {28'h0000000, in_cal, no_reference_flag_reg, error_reg, ready_reg};

   // Merge write data into a register under byte enables
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0]        be);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ****************************************************
   // Avalon slave: one wait cycle per access
   // ****************************************************
   always_comb begin
      wait_next  = 1'b1;
      rdata_next = rdata_reg;
      // Drop waitrequest one cycle after a request appears
      if ((avs_req.read || avs_req.write) && wait_reg) begin
         wait_next = 1'b0;
      end
      // Capture read data during the wait cycle
      if (avs_req.read && wait_reg) begin
         case (avs_req.address)
            OFS_CONFIG:    rdata_next = {26'h0, config_reg};
            OFS_MODE:      rdata_next = {28'h0000000, op_reg, clk_sel_reg};
            OFS_STATUS:    rdata_next = status_word;
            OFS_DATA:      rdata_next = {8'h00, data_reg};
            OFS_OFFSET:    rdata_next = {8'h00, offset_reg};
            OFS_FULLSCALE: rdata_next = {8'h00, fullscale_reg};
            OFS_GPO:       rdata_next = {29'h0, gpo_reg};
            default:       rdata_next = '0;                  // Unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= '0;
      end else begin
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************************
   // Control registers and calibration
   // ****************************************************
   always_comb begin
      logic [DATA_W-1:0] m;
      m               = '0;
      config_next     = config_reg;
      clk_sel_next    = clk_sel_reg;
      op_next         = op_reg;
      offset_next     = offset_reg;
      fullscale_next  = fullscale_reg;
      gpo_next        = gpo_reg;
      no_reference_flag_seen_next = no_reference_flag_seen_reg;
      // Software writes
      if (take_wr) begin
         case (avs_req.address)
            OFS_CONFIG: begin
               m           = merge({26'h0, config_reg}, avs_req.writedata, avs_req.byteenable);
               config_next = m[5:0];
            end
            OFS_MODE: begin
               m            = merge({28'h0000000, op_reg, clk_sel_reg}, avs_req.writedata,
                                    avs_req.byteenable);
               clk_sel_next = m[MODE_CLK_HI:MODE_CLK_LO];    // [RULE4]
               op_next      = op_mode_t'(m[MODE_OP_LO +: 2]);
               // Any mode write, including one that starts a calibration, forgets earlier reference loss
               no_reference_flag_seen_next = 1'b0;
            end
            OFS_OFFSET: begin
               m           = merge({8'h00, offset_reg}, avs_req.writedata, avs_req.byteenable);
               offset_next = m[RES_W-1:0];
            end
            OFS_FULLSCALE: begin
               m              = merge({8'h00, fullscale_reg}, avs_req.writedata, avs_req.byteenable);
               fullscale_next = m[RES_W-1:0];
            end
            OFS_GPO: begin
               m        = merge({29'h0, gpo_reg}, avs_req.writedata, avs_req.byteenable);
               gpo_next = m[2:0];
            end
            default: begin
               m = '0;                                       // Other writes ignored
            end
         endcase
      end
      // Track reference loss while calibrating
      if (in_cal && no_reference_flag_reg) begin
         no_reference_flag_seen_next = 1'b1;                             // [RULE11]
      end
      // Calibration end: store coefficient only with a good reference
      if (in_cal && cal_sample.valid) begin
         op_next = OP_IDLE;
         if (!(no_reference_flag_seen_reg || no_reference_flag_reg)) begin
            if (op_reg == OP_CAL_ZERO) begin
               offset_next = cal_sample.value;
            end else begin
               fullscale_next = cal_sample.value;
            end
         end                                                 // [RULE11]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config_reg     <= CONFIG_RST;
         clk_sel_reg    <= MODE_RST[1:0];
         op_reg         <= op_mode_t'(MODE_RST[3:2]);
         offset_reg     <= OFFSET_RST;
         fullscale_reg  <= FULLSCALE_RST;
         gpo_reg        <= 3'h0;
         no_reference_flag_seen_reg <= 1'b0;
      end else begin
         config_reg     <= config_next;
         clk_sel_reg    <= clk_sel_next;
         op_reg         <= op_next;
         offset_reg     <= offset_next;
         fullscale_reg  <= fullscale_next;
         gpo_reg        <= gpo_next;
         no_reference_flag_seen_reg <= no_reference_flag_seen_next;
      end
   end

   // ****************************************************
   // Status flags and result register
   // ****************************************************
   always_comb begin
      data_next  = data_reg;
      ready_next = ready_reg;
      error_next = error_reg;
      // Detection gated by its enable bit
      no_reference_flag_next = config_reg[CFG_REFERENCE_DETECT_ENABLE] & ref_bad;         // [RULE8] [RULE9]
      // Reading the result clears ready
      if (take_rd && (avs_req.address == OFS_DATA)) begin
         ready_next = 1'b0;
      end
      // Write one to clear the error flag
      if (take_wr && (avs_req.address == OFS_STATUS) && avs_req.byteenable[0]
          && avs_req.writedata[ST_ERROR]) begin
         error_next = 1'b0;
      end
      // New conversion in normal mode, set wins over clear
      if (conv_sample.valid && (op_reg == OP_CONT)) begin
         data_next  = coded;                                 // [RULE14]
         ready_next = 1'b1;
      end
      // Calibration ended without a reference
      if (in_cal && cal_sample.valid && (no_reference_flag_seen_reg || no_reference_flag_reg)) begin
         error_next = 1'b1;                                  // [RULE11]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_reg  <= '0;
         ready_reg <= 1'b0;
         error_reg <= 1'b0;
         no_reference_flag_reg <= 1'b0;
      end else begin
         data_reg  <= data_next;
         ready_reg <= ready_next;
         error_reg <= error_next;
         no_reference_flag_reg <= no_reference_flag_next;
      end
   end

   // ****************************************************
   // Analog controls and pins
   // ****************************************************
   always_comb begin
      // Clock pin driven only in internal-out choice
      clk_oe_next  = (clk_sel_reg == CLK_INT_OUT);           // [RULE5]
      clk_pin_next = clk_oe_next & osc_sync;                 // [RULE5]
      // One bit drives both generators
      burn_next    = config_reg[CFG_BURNOUT];                // [RULE6]
      chan_next    = config_reg[CFG_CHAN_LO +: 2];           // [RULE6]
      reference_select_next  = config_reg[CFG_REFERENCE_SELECT];                 // [RULE7]
      // Second pair is reference input when selected
      pin_oe_next  = {2{gpo_reg[GPO_EN] & ~config_reg[CFG_REFERENCE_SELECT]}}; // [RULE7]
      pin_out_next = gpo_reg[1:0] & pin_oe_next;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_oe_reg  <= 1'b0;
         clk_pin_reg <= 1'b0;
         burn_reg    <= 1'b0;
         chan_reg    <= 2'h0;
         reference_select_reg  <= 1'b0;
         pin_oe_reg  <= 2'h0;
         pin_out_reg <= 2'h0;
      end else begin
         clk_oe_reg  <= clk_oe_next;
         clk_pin_reg <= clk_pin_next;
         burn_reg    <= burn_next;
         chan_reg    <= chan_next;
         reference_select_reg  <= reference_select_next;
         pin_oe_reg  <= pin_oe_next;
         pin_out_reg <= pin_out_next;
      end
   end

   // Outputs straight from flops
   assign avs_readdata              = rdata_reg;
   assign avs_waitrequest           = wait_reg;
   assign clock_source              = clk_sel_reg;
   assign master_clock_pin_b_out    = clk_pin_reg;
   assign master_clock_pin_b_oe     = clk_oe_reg;
   assign burnout_source_en         = burn_reg;
   assign burnout_sink_en           = burn_reg;
   assign burnout_channel           = chan_reg;
   assign reference_select          = reference_select_reg;
   assign second_reference_pair_out = pin_out_reg;
   assign second_reference_pair_oe  = pin_oe_reg;
   assign op_mode                   = op_reg;

endmodule : adc_result_coding_ref_monitor

// ---- rtl/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

   // ****************************************************
   // Bus geometry
   // ****************************************************
   localparam int ADDR_W = 5;                                // Byte address width
   localparam int DATA_W = 32;                               // Bus data width
   localparam int RES_W  = 24;                               // Result width

   // ****************************************************
   // Register byte offsets
   // ****************************************************
   localparam logic [ADDR_W-1:0] OFS_CONFIG    = 5'h00;      // Configuration
   localparam logic [ADDR_W-1:0] OFS_MODE      = 5'h04;      // Mode
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h08;      // Status
   localparam logic [ADDR_W-1:0] OFS_DATA      = 5'h0c;      // Conversion result
   localparam logic [ADDR_W-1:0] OFS_OFFSET    = 5'h10;      // Offset coefficient
   localparam logic [ADDR_W-1:0] OFS_FULLSCALE = 5'h14;      // Full-scale coefficient
   localparam logic [ADDR_W-1:0] OFS_GPO       = 5'h18;      // Second pair outputs

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int CFG_UNIPOLAR  = 0;                         // 1 unipolar, 0 bipolar
   localparam int CFG_BURNOUT   = 1;                         // Burnout current enable
   localparam int CFG_REFERENCE_SELECT    = 2;                         // Reference select
   localparam int CFG_REFERENCE_DETECT_ENABLE    = 3;                         // Reference detect enable
   localparam int CFG_CHAN_LO   = 4;                         // Channel field low bit
   localparam int MODE_CLK_LO   = 0;                         // Clock select low bit
   localparam int MODE_CLK_HI   = 1;                         // Clock select high bit
   localparam int MODE_OP_LO    = 2;                         // Operating mode low bit
   localparam int ST_READY      = 0;                         // New result waiting
   localparam int ST_ERROR      = 1;                         // Calibration error
   localparam int ST_NO_REFERENCE_FLAG      = 2;                         // No valid reference
   localparam int ST_CALBUSY    = 3;                         // Calibration running
   localparam int GPO_EN        = 2;                         // Second pair output enable

   // ****************************************************
   // Encodings and reset values
   // ****************************************************
   typedef enum logic [1:0] {
      CLK_XTAL, CLK_EXT_IN, CLK_INT, CLK_INT_OUT
   } clk_sel_t;                                              // Clock source choice

   typedef enum logic [1:0] {
      OP_CONT, OP_IDLE, OP_CAL_ZERO, OP_CAL_FULL
   } op_mode_t;                                              // Operating modes

   localparam logic [5:0]       CONFIG_RST    = 6'h00;       // Bipolar, all off
   localparam logic [3:0]       MODE_RST      = 4'h2;        // Internal clock, continuous
   localparam logic [RES_W-1:0] OFFSET_RST    = 24'h800000;  // Midscale offset
   localparam logic [RES_W-1:0] FULLSCALE_RST = 24'h500000;  // Nominal gain word
   localparam logic [RES_W-1:0] RES_MIDSCALE  = 24'h800000;  // Only the top bit set
   localparam logic [RES_W-1:0] RES_ALL_ONES  = 24'hffffff;  // Clamp value

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic              read;                               // Read strobe
      logic              write;                              // Write strobe
      logic [ADDR_W-1:0] address;                            // Byte address
      logic [DATA_W-1:0] writedata;                          // Write data
      logic [3:0]        byteenable;                         // Byte lanes
   } avs_req_t;

   typedef struct packed {
      logic             valid;                               // One-cycle pulse
      logic [RES_W-1:0] value;                               // Signed fraction of full scale
   } sample_t;

endpackage : adc_ctrl_pkg

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
// ****************************************************
// Two-stage synchroniser, one per bit
// ****************************************************
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_reg;                                     // First stage, read only by second
         logic hold_reg;                                     // Second stage

         // Two flops in series
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_reg <= 1'b0;
               hold_reg <= 1'b0;
            end else begin
               meta_reg <= async_in[i];
               hold_reg <= meta_reg;
            end
         end

         assign sync_out[i] = hold_reg;
      end
   endgenerate

endmodule : pin_sync

// ---- rtl/result_coder.sv ----
`timescale 1ns/1ps
// ****************************************************
// Result coding and reference clamp
// ****************************************************
module result_coder
   import adc_ctrl_pkg::*;
(
   input  wire logic             unipolar,
   input  wire logic             clamp,
   input  wire logic [RES_W-1:0] value,
   output      logic [RES_W-1:0] code
);

   // Map signed fraction to output code
   always_comb begin
      if (clamp) begin
         code = RES_ALL_ONES;                                // [RULE10] [RULE14]
      end else if (unipolar) begin
         // Negative input floors at zero, top half doubles
         if (value[RES_W-1]) begin
            code = '0;                                       // [RULE1]
         end else begin
            code = {value[RES_W-2:0], &value[RES_W-2:0]};    // [RULE1]
         end
      end else begin
         code = value ^ RES_MIDSCALE;                        // [RULE2]
      end
   end

endmodule : result_coder

// ---- tb/adc_ctrl_assertions.sv ----
`timescale 1ns/1ps
// ****
// Pin and mirror checks
// ****
module adc_ctrl_assertions
   import adc_ctrl_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   arst_n,
   input wire adc_ctrl_pkg::avs_req_t avs_req,
   input wire logic                   avs_waitrequest,
   input wire adc_ctrl_pkg::sample_t  cal_sample,
   input wire logic [1:0]             clock_source,
   input wire logic                   master_clock_pin_b_out,
   input wire logic                   master_clock_pin_b_oe,
   input wire logic                   burnout_source_en,
   input wire logic                   burnout_sink_en,
   input wire logic [1:0]             burnout_channel,
   input wire logic                   reference_select,
   input wire logic [1:0]             second_reference_pair_oe,
   input wire logic [1:0]             op_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic tk;   // Write taken this edge
   logic cw;   // Config write taken
   logic mw;   // Mode write taken
   assign tk = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];
   assign cw = tk && avs_req.address == OFS_CONFIG;
   assign mw = tk && avs_req.address == OFS_MODE;
   burn_pair_a: assert property (burnout_source_en == burnout_sink_en) else $error("burnout split");
   clk_out_a: assert property (master_clock_pin_b_oe == ($past(clock_source) == 2'h3)) else $error("pin oe");
   pin_quiet_a: assert property (!master_clock_pin_b_oe |-> !master_clock_pin_b_out) else $error("pin out");
   pair_free_a: assert property (reference_select |-> second_reference_pair_oe == 2'h0) else $error("pair oe");
   clk_sel_a: assert property (mw |=> ##1 clock_source == $past(avs_req.writedata[1:0], 2)) else $error("clk sel");
   burn_cfg_a: assert property (cw |=> ##1 burnout_source_en == $past(avs_req.writedata[1], 2)) else $error("burn");
   chan_cfg_a: assert property (cw |=> ##1 burnout_channel == $past(avs_req.writedata[5:4], 2)) else $error("chan");
   ref_cfg_a: assert property (cw |=> ##1 reference_select == $past(avs_req.writedata[2], 2)) else $error("reference_select");
   cal_idle_a: assert property (cal_sample.valid && op_mode[1] && !avs_req.write |-> ##2 op_mode == 2'h1) else $error("cal");
   cover property (cw);
   cover property (mw);
   cover property (cal_sample.valid && op_mode[1]);
endmodule : adc_ctrl_assertions
bind adc_result_coding_ref_monitor adc_ctrl_assertions chk (.*);

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// ****
// Host reading results
// ****
module host_model
   import adc_ctrl_pkg::*;
(
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0] avs_readdata,
   input  wire logic                            avs_waitrequest,
   input  wire logic                            clk,
   output adc_ctrl_pkg::avs_req_t               avs_req
);
   logic [DATA_W-1:0] s;   // Status scratch
   initial avs_req = '0;
   // One held request, released after the answer edge
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
      @(posedge clk);
      avs_req <= '{!w, w, a, d, 4'hf};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_req <= '0;
   endtask : xfer
   // Flag looked at only on an all-ones word
   task automatic result(output logic [DATA_W-1:0] d, output logic nr);
      xfer(1'b0, OFS_DATA, '0, d);
      nr = 1'b0;
      if (d[RES_W-1:0] === RES_ALL_ONES) begin
         xfer(1'b0, OFS_STATUS, '0, s);
         nr = s[ST_NO_REFERENCE_FLAG];
      end
   endtask : result
   // Error bit read once calibration is over
   task automatic cal_error(output logic e);
      xfer(1'b0, OFS_STATUS, '0, s);
      e = s[ST_ERROR];
   endtask : cal_error
endmodule : host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// ****
// Result coding and reference bench
// ****
module testbench;
   import adc_ctrl_pkg::*;
   logic       clk = 0, arst_n = 0, ref_invalid_pin = 0, internal_osc = 0, avs_waitrequest, nr;
   logic       master_clock_pin_b_out, master_clock_pin_b_oe, burnout_source_en, burnout_sink_en, reference_select;
   logic [1:0] clock_source, burnout_channel, second_reference_pair_out, second_reference_pair_oe, op_mode;
   logic [31:0] avs_readdata, q;
   logic [23:0] r, vals[$] = '{24'h000000, 24'h400000, 24'h7fffff, 24'h800000, 24'hc00000};
   avs_req_t   avs_req;
   sample_t    conv_sample = '0, cal_sample = '0;
   int         errors = 0, n_checks = 0;
   always #10 clk = ~clk;
   always @(posedge clk) internal_osc <= 1'($urandom);
   adc_result_coding_ref_monitor dut (.*);
   host_model h (.*);
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Expected word from the coding rules
   function automatic logic [31:0] code(input int u, input logic [23:0] x);
      int s;
      s = $signed(x);
      if (u == 0) return 32'(s + 32'h800000) & 32'hffffff;
      return (s < 0) ? 0 : 32'(2 * s + int'(s == 32'h7fffff));
   endfunction : code
   // One-cycle sample pulse
   task pulse(input logic c, input logic [23:0] x);
      @(posedge clk);
      if (c) cal_sample <= '{1'b1, x};
      else conv_sample <= '{1'b1, x};
      @(posedge clk);
      cal_sample <= '0;
      conv_sample <= '0;
   endtask : pulse
   task tally_and_finish;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hf174e303));
      vals.push_back(24'($urandom));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      h.xfer(1'b0, OFS_MODE, '0, q);
      chk(q, 32'h2);
      h.xfer(1'b0, 5'h1c, '0, q);
      chk(q, 32'h0);
      for (int u = 0; u < 2; u++) begin
         h.xfer(1'b1, OFS_CONFIG, 32'(u), q);
         foreach (vals[i]) begin
            pulse(1'b0, vals[i]);
            h.xfer(1'b0, OFS_DATA, '0, q);
            chk(q, code(u, vals[i]));
         end
      end
      ref_invalid_pin <= 1'b1;
      h.xfer(1'b1, OFS_CONFIG, 32'h0, q);
      pulse(1'b0, vals[5]);
      h.result(q, nr);
      chk(q, code(0, vals[5]));
      h.xfer(1'b1, OFS_CONFIG, 32'h8, q);
      repeat (5) @(posedge clk);
      pulse(1'b0, vals[5]);
      h.result(q, nr);
      chk(q, 32'hffffff);
      chk(32'(nr), 32'h1);
      h.xfer(1'b0, OFS_DATA, '0, q);
      chk(q, 32'hffffff);
      ref_invalid_pin <= 1'b0;
      repeat (5) @(posedge clk);
      r = 24'($urandom);
      h.xfer(1'b1, OFS_MODE, 32'ha, q);
      pulse(1'b1, r);
      h.cal_error(nr);
      chk(32'(nr), 32'h0);
      h.xfer(1'b0, OFS_OFFSET, '0, q);
      chk(q, 32'(r));
      ref_invalid_pin <= 1'b1;
      h.xfer(1'b1, OFS_MODE, 32'he, q);
      repeat (5) @(posedge clk);
      pulse(1'b1, ~r);
      h.cal_error(nr);
      chk(32'(nr), 32'h1);
      h.xfer(1'b0, OFS_FULLSCALE, '0, q);
      chk(q, 32'h500000);
      for (int k = 0; k < 4; k++) begin
         h.xfer(1'b1, OFS_MODE, 32'(4 + k), q);
         repeat (3) @(posedge clk);
         chk(32'(clock_source), 32'(k));
         chk(32'(master_clock_pin_b_oe), 32'(k == 3));
      end
      h.xfer(1'b1, OFS_GPO, 32'h7, q);
      for (int s = 0; s < 2; s++) begin
         h.xfer(1'b1, OFS_CONFIG, s ? 32'h36 : 32'h12, q);
         repeat (3) @(posedge clk);
         chk(32'(second_reference_pair_oe), s ? 32'h0 : 32'h3);
         chk(32'(second_reference_pair_out), s ? 32'h0 : 32'h3);
         chk(32'({burnout_channel, burnout_source_en, burnout_sink_en}), s ? 32'hf : 32'h7);
      end
      tally_and_finish();
   end
endmodule : testbench
